/* File: verilog/burst_sram_defs.vh */
// Widths, field positions and reset values shared by the burst SRAM port files.
`ifndef BURST_SRAM_DEFS_VH
`define BURST_SRAM_DEFS_VH

// Address, data and lane sizes of the storage array.
`define ADDR_WIDTH       19
`define MEM_DEPTH        524288
`define DATA_WIDTH       32
`define LANE_COUNT       4
`define LANE_BITS        8
`define WORD_WIDTH       36

// Field positions inside one queued write entry.
`define ENTRY_WIDTH      59
`define ENTRY_DATA_LSB   0
`define ENTRY_PAR_LSB    32
`define ENTRY_MASK_LSB   36
`define ENTRY_ADDR_LSB   40

// Depth of the write queue in front of the array.
`define QUEUE_DEPTH      4
`define QUEUE_PTR_WIDTH  2
`define QUEUE_CNT_WIDTH  3

// Burst offset field and its reset value.
`define OFFSET_WIDTH     2
`define OFFSET_RESET     2'h0

// Reset values of the pipeline and output registers.
`define VALID_RESET      1'h0
`define DATA_RESET       32'h0000_0000
`define PARITY_RESET     4'h0
`define SYNC_RESET       2'h0

`endif

/* File: verilog/burst_offset_gen.v */
// Two-bit burst offset sequencer for linear and interleaved burst order.
`timescale 1ns/1ps
`include "burst_sram_defs.vh"

module burst_offset_gen
(
  // Start offset and step number within the burst.
  input  wire [`OFFSET_WIDTH-1:0] startOffset,
  input  wire [`OFFSET_WIDTH-1:0] stepCount,
  // High selects interleaved order.
  input  wire                     interleaved,
  // Offset of this step.
  output wire [`OFFSET_WIDTH-1:0] stepOffset
);

  // Both forms touch only the two low bits, so the sequence wraps in a group of four.
  wire [`OFFSET_WIDTH-1:0] linearOffset;
  wire [`OFFSET_WIDTH-1:0] interleavedOffset;

  assign linearOffset      = startOffset + stepCount;
  assign interleavedOffset = startOffset ^ stepCount;
  assign stepOffset        = interleaved ? interleavedOffset : linearOffset;

endmodule

/* File: verilog/write_queue.v */
// Small synchronous FIFO holding captured writes on their way into the array.
`timescale 1ns/1ps

module write_queue
#(
  parameter WIDTH     = 59,
  parameter DEPTH     = 4,
  parameter PTR_WIDTH = 2,
  parameter CNT_WIDTH = 3
)
(
  // Clock and reset.
  input  wire             clock,
  input  wire             rst,
  // Filling side.
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Draining side.
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0]     entries [0:DEPTH-1];
  reg [PTR_WIDTH-1:0] writePtr_r;
  reg [PTR_WIDTH-1:0] readPtr_r;
  reg [CNT_WIDTH-1:0] count_r;
  wire                push;
  wire                pop;

  // Full and empty come straight from the occupancy count.
  assign inReady  = (count_r != DEPTH[CNT_WIDTH-1:0]);
  assign outValid = (count_r != {CNT_WIDTH{1'b0}});
  assign outData  = entries[readPtr_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Pointers wrap naturally because the depth is a power of two.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      writePtr_r <= {PTR_WIDTH{1'b0}};
      readPtr_r  <= {PTR_WIDTH{1'b0}};
      count_r    <= {CNT_WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        writePtr_r <= writePtr_r + 1'b1;
      if (pop)
        readPtr_r <= readPtr_r + 1'b1;
      if (push & ~pop)
        count_r <= count_r + 1'b1;
      else if (pop & ~push)
        count_r <= count_r - 1'b1;
    end
  end

  // Storage is not reset; only valid slots are ever read.
  always @(posedge clock)
  begin
    if (push)
      entries[writePtr_r] <= inData;
  end

endmodule

/* File: verilog/burst_sram_port.v */
// Pipelined burst SRAM device: command pipeline, burst counter, array and output drivers.
// What this block does
// - Capture synchronous inputs and update data outputs on the rising clock edge.
// - Clock qualifier high freezes pipeline, burst and array state for that edge; the sleep and strap synchronisers still move.
// - Qualified edge, all selects active, write strobe high, load low starts a read.
// - Read data leaves the output register one edge later, driven only if enable low.
// - A new command is accepted the cycle right after a read.
// - Deselect is pipelined; outputs float after the following edge.
// - Burst counter gives up to four accesses from one loaded address.
// - Burst-order strap low selects linear, high selects interleaved.
// - Bursts change only the two low address bits and wrap within four.
// - Advance_load high advances the burst, ignoring selects and write strobe.
// - Write strobe is taken only at burst start and kept for the burst.
// - Qualified edge, all selects active, write strobe low starts a write.
// - Edge after a write floats data outputs and accepts the next command.
// - Write data is captured on the second edge after the write command.
// - Only lanes whose active-low write select is low are updated.
// - Sleep request is asynchronous, takes two cycles, keeps stored data.
// - Accesses pending at sleep entry are dropped as invalid.
// - After a read's first clock, output drive needs both enable low and control.
// - Interleaved order XORs the start offset with the step count.
// - Linear order adds one modulo four each step.
// - Power-up leaves the device deselected with outputs floating.
`timescale 1ns/1ps
`include "burst_sram_defs.vh"

module burst_sram_port
(
  // Clock and power-up reset.
  input  wire                     clock,
  input  wire                     rst,
  // Synchronous command inputs from the controller.
  input  wire                     clockQualifierN,
  input  wire                     chipSelectFirstN,
  input  wire                     chipSelectSecond,
  input  wire                     chipSelectThirdN,
  input  wire                     advanceLoad,
  input  wire                     writeEnableN,
  input  wire [`LANE_COUNT-1:0]   byteLaneWriteSelectN,
  input  wire [`ADDR_WIDTH-1:0]   address,
  // Asynchronous and strap inputs.
  input  wire                     outputDriveEnableN,
  input  wire                     burstOrder,
  input  wire                     sleepRequest,
  // Shared data and parity lanes, split into in, out and enable.
  input  wire [`DATA_WIDTH-1:0]   dataIn,
  input  wire [`LANE_COUNT-1:0]   parityLanesIn,
  output wire [`DATA_WIDTH-1:0]   dataOut,
  output wire [`LANE_COUNT-1:0]   parityLanesOut,
  output wire                     dataOe,
  // Sleep state, visible for system use.
  output wire                     asleep
);

  // Synchronisers for the two inputs that do not come from the clock domain.
  reg  [1:0]                sleepSync_r;
  reg  [1:0]                orderSync_r;

  // Burst state.
  reg                       burstActive_r;
  reg                       burstWrite_r;
  reg  [`ADDR_WIDTH-1:0]    burstBase_r;
  reg  [`OFFSET_WIDTH-1:0]  burstStep_r;

  // First pipeline stage: the command taken at the last edge.
  reg                       s1Valid_r;
  reg                       s1Write_r;
  reg  [`ADDR_WIDTH-1:0]    s1Addr_r;
  reg  [`LANE_COUNT-1:0]    s1Mask_r;

  // Second pipeline stage: a write waiting for its data.
  reg                       s2Write_r;
  reg  [`ADDR_WIDTH-1:0]    s2Addr_r;
  reg  [`LANE_COUNT-1:0]    s2Mask_r;

  // Output register and its drive qualifier.
  reg  [`DATA_WIDTH-1:0]    dataOut_r;
  reg  [`LANE_COUNT-1:0]    parityOut_r;
  reg                       readDrive_r;

  // Storage array: data in the low bits, lane parity above.
  reg  [`WORD_WIDTH-1:0]    memory [0:`MEM_DEPTH-1];

  wire                      allSelected;
  wire                      advance;
  wire                      queueReady;
  wire                      queueValid;
  wire [`ENTRY_WIDTH-1:0]   queueHead;
  wire [`ENTRY_WIDTH-1:0]   captureEntry;
  wire                      captureValid;
  wire [`OFFSET_WIDTH-1:0]  nextStep;
  wire [`OFFSET_WIDTH-1:0]  nextOffset;
  wire [`ADDR_WIDTH-1:0]    nextBurstAddr;
  wire [`ADDR_WIDTH-1:0]    headAddr;
  wire [`LANE_COUNT-1:0]    headMaskN;
  wire [`WORD_WIDTH-1:0]    oldWord;
  wire [`WORD_WIDTH-1:0]    mergedWord;
  wire [`WORD_WIDTH-1:0]    readWord;
  wire                      drain;
  wire                      s1Read;

  // The strap should stay still, but an untied pin may wander, so it is synchronised too.
  // Sleep and strap levels each pass two flops; only the second flop is read.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sleepSync_r <= `SYNC_RESET;
      orderSync_r <= `SYNC_RESET;
    end
    else
    begin
      sleepSync_r <= {sleepSync_r[0], sleepRequest};
      orderSync_r <= {orderSync_r[0], burstOrder};
    end
  end

  // Two clocks after the request changes, the device enters or leaves sleep.
  assign asleep = sleepSync_r[1];

  // Chip selects: first and third active low, second active high.
  // Any one of them inactive at a load edge turns that edge into a deselect.
  assign allSelected = ~chipSelectFirstN & chipSelectSecond & ~chipSelectThirdN;

  // A full write queue also holds the pipeline, so no captured write is ever lost.
  // Captures and drains share the same qualified edges, so in practice it never fills.
  assign advance = ~clockQualifierN & ~asleep & queueReady;

  // Next burst step; a 2-bit step wraps after the fourth access.
  // The step restarts from zero at every load edge, so each burst begins at its own address.
  assign nextStep = burstStep_r + 1'b1;

  burst_offset_gen offsetGen
  (
    .startOffset (burstBase_r[`OFFSET_WIDTH-1:0]),
    .stepCount   (nextStep),
    .interleaved (orderSync_r[1]),
    .stepOffset  (nextOffset)
  );

  // Upper address bits never change within a burst.
  assign nextBurstAddr = {burstBase_r[`ADDR_WIDTH-1:`OFFSET_WIDTH], nextOffset};

  // Command decode and burst counter, taken at each qualified edge.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      burstActive_r <= `VALID_RESET;
      burstWrite_r  <= `VALID_RESET;
      burstBase_r   <= {`ADDR_WIDTH{1'b0}};
      burstStep_r   <= `OFFSET_RESET;
      s1Valid_r     <= `VALID_RESET;
      s1Write_r     <= `VALID_RESET;
      s1Addr_r      <= {`ADDR_WIDTH{1'b0}};
      s1Mask_r      <= {`LANE_COUNT{1'b1}};
    end
    else if (asleep)
    begin
      // Anything in flight at sleep entry is abandoned.
      burstActive_r <= `VALID_RESET;
      s1Valid_r     <= `VALID_RESET;
    end
    else if (advance)
    begin
      s1Mask_r <= byteLaneWriteSelectN;
      if (!advanceLoad)
      begin
        // Load edge: either a new burst or a deselect.
        s1Addr_r    <= address;
        burstBase_r <= address;
        burstStep_r <= `OFFSET_RESET;
        if (allSelected)
        begin
          burstActive_r <= 1'b1;
          burstWrite_r  <= ~writeEnableN;
          s1Valid_r     <= 1'b1;
          s1Write_r     <= ~writeEnableN;
        end
        else
        begin
          burstActive_r <= 1'b0;
          s1Valid_r     <= 1'b0;
          s1Write_r     <= 1'b0;
        end
      end
      else
      begin
        // Continue edge: selects and write strobe are not looked at.
        burstStep_r <= nextStep;
        s1Addr_r    <= nextBurstAddr;
        s1Valid_r   <= burstActive_r;
        s1Write_r   <= burstWrite_r;
      end
    end
  end

  // The array is read combinationally from the first stage address.
  // Limitation: a read within two commands of a write to the same word sees the old
  // word, since the write reaches the array only one edge after its data edge.
  assign readWord = memory[s1Addr_r];

  // A first stage read, as opposed to a write, a deselect or an empty slot.
  assign s1Read = s1Valid_r & ~s1Write_r;

  // Second edge: reads load the output register, writes move on toward their data.
  // This stage moves on at every qualified edge, which frees the first for a new command.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s2Write_r   <= `VALID_RESET;
      s2Addr_r    <= {`ADDR_WIDTH{1'b0}};
      s2Mask_r    <= {`LANE_COUNT{1'b1}};
      dataOut_r   <= `DATA_RESET;
      parityOut_r <= `PARITY_RESET;
      readDrive_r <= `VALID_RESET;
    end
    else if (asleep)
    begin
      // In-flight accesses are dropped; writes already queued are kept.
      s2Write_r   <= `VALID_RESET;
      readDrive_r <= `VALID_RESET;
    end
    else if (advance)
    begin
      s2Write_r <= s1Valid_r & s1Write_r;
      s2Addr_r  <= s1Addr_r;
      s2Mask_r  <= s1Mask_r;
      // Writes and deselects leave the drivers off after this edge.
      readDrive_r <= s1Read;
      if (s1Read)
      begin
        dataOut_r   <= readWord[`DATA_WIDTH-1:0];
        parityOut_r <= readWord[`WORD_WIDTH-1:`DATA_WIDTH];
      end
    end
  end

  // Output enable is asynchronous and only gates an already qualified read.
  // Sleep floats the lanes at once instead of waiting for the pipeline to empty.
  assign dataOe         = readDrive_r & ~outputDriveEnableN & ~asleep;
  assign dataOut        = dataOut_r;
  assign parityLanesOut = parityOut_r;

  // Third edge: write data from the lanes is captured into the queue.
  assign captureValid = advance & s2Write_r;
  assign captureEntry = {s2Addr_r, s2Mask_r, parityLanesIn, dataIn};

  // The queue sits between the data edge and the array, so a stall never drops a write.
  write_queue
  #(
    .WIDTH     (`ENTRY_WIDTH),
    .DEPTH     (`QUEUE_DEPTH),
    .PTR_WIDTH (`QUEUE_PTR_WIDTH),
    .CNT_WIDTH (`QUEUE_CNT_WIDTH)
  )
  writeQueue
  (
    .clock    (clock),
    .rst      (rst),
    .inValid  (captureValid),
    .inReady  (queueReady),
    .inData   (captureEntry),
    .outValid (queueValid),
    .outReady (drain),
    .outData  (queueHead)
  );

  // The array core stops while stalled or asleep, on the same edges that stop captures.
  assign drain     = ~clockQualifierN & ~asleep;
  assign headAddr  = queueHead[`ENTRY_ADDR_LSB +: `ADDR_WIDTH];
  assign headMaskN = queueHead[`ENTRY_MASK_LSB +: `LANE_COUNT];
  assign oldWord   = memory[headAddr];

  // Each lane merges its byte and its parity bit under its own select.
  // A masked lane takes its old bits back, so a byte write is a read-modify-write.
  genvar lane;
  generate
    for (lane = 0; lane < `LANE_COUNT; lane = lane + 1)
    begin : laneMerge
      assign mergedWord[lane*`LANE_BITS +: `LANE_BITS] = headMaskN[lane] ?
        oldWord[lane*`LANE_BITS +: `LANE_BITS] :
        queueHead[`ENTRY_DATA_LSB + lane*`LANE_BITS +: `LANE_BITS];
      assign mergedWord[`DATA_WIDTH + lane] = headMaskN[lane] ?
        oldWord[`DATA_WIDTH + lane] :
        queueHead[`ENTRY_PAR_LSB + lane];
    end
  endgenerate

  // Array write; storage is never cleared, so sleep keeps its contents.
  always @(posedge clock)
  begin
    if (queueValid & drain)
      memory[headAddr] <= mergedWord;
  end

endmodule

/* File: test/burst_sram_port_asserts.sv */
// Pin-level checks on the burst SRAM port.
`timescale 1ns/1ps
`include "burst_sram_defs.vh"

module burst_sram_port_asserts
(
  // Clock and reset.
  input wire                   clock,
  input wire                   rst,
  // Commands and control.
  input wire                   clockQualifierN,
  input wire                   chipSelectFirstN,
  input wire                   chipSelectSecond,
  input wire                   chipSelectThirdN,
  input wire                   advanceLoad,
  input wire                   writeEnableN,
  input wire                   outputDriveEnableN,
  input wire                   sleepRequest,
  // Device outputs.
  input wire [`DATA_WIDTH-1:0] dataOut,
  input wire [`LANE_COUNT-1:0] parityLanesOut,
  input wire                   dataOe,
  input wire                   asleep
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Decoded edges; sleep blocks every command.
  wire go     = !clockQualifierN && !asleep;
  wire load   = go && !advanceLoad;
  wire selAll = !chipSelectFirstN && chipSelectSecond && !chipSelectThirdN;
  property p_stall;
    clockQualifierN && !asleep |=> $stable({parityLanesOut, dataOut});
  endproperty
  property p_read;
    load && selAll && writeEnableN ##1 go |=> dataOe == (!outputDriveEnableN && !asleep);
  endproperty
  property p_write;
    load && selAll && !writeEnableN ##1 go |=> !dataOe;
  endproperty
  property p_desel;
    load && !selAll ##1 go |=> !dataOe;
  endproperty
  property p_gate;
    dataOe |-> !outputDriveEnableN;
  endproperty
  property p_sleep_in;
    $rose(sleepRequest) |=> !asleep ##1 asleep;
  endproperty
  property p_sleep_out;
    $fell(sleepRequest) |=> asleep ##1 !asleep;
  endproperty
  property p_power_up;
    disable iff (1'b0) rst |-> !dataOe && !asleep;
  endproperty
  property p_sleep_float;
    asleep |-> !dataOe;
  endproperty
  a_stall: assert property (p_stall) else $error("stalled edge moved data");
  a_read: assert property (p_read) else $error("read not driven");
  a_write: assert property (p_write) else $error("lanes driven after write");
  a_desel: assert property (p_desel) else $error("lanes driven after deselect");
  a_gate: assert property (p_gate) else $error("drive with enable high");
  a_sleep_in: assert property (p_sleep_in) else $error("sleep entry timing");
  a_sleep_out: assert property (p_sleep_out) else $error("sleep exit timing");
  a_power_up: assert property (p_power_up) else $error("reset state wrong");
  a_sleep_float: assert property (p_sleep_float) else $error("driven asleep");
  c_read: cover property (load && selAll && writeEnableN);
  c_write: cover property (load && selAll && !writeEnableN);
  c_burst: cover property (go && advanceLoad);
  c_sleep: cover property (asleep);
endmodule

bind burst_sram_port burst_sram_port_asserts chk_u
(
  .clock(clock), .rst(rst), .clockQualifierN(clockQualifierN),
  .chipSelectFirstN(chipSelectFirstN), .chipSelectSecond(chipSelectSecond),
  .chipSelectThirdN(chipSelectThirdN), .advanceLoad(advanceLoad),
  .writeEnableN(writeEnableN), .outputDriveEnableN(outputDriveEnableN),
  .sleepRequest(sleepRequest), .dataOut(dataOut), .parityLanesOut(parityLanesOut),
  .dataOe(dataOe), .asleep(asleep)
);

/* File: test/lane_driver.sv */
// Controller side of the shared data and parity lanes.
`timescale 1ns/1ps

module lane_driver
(
  // Clock.
  input  wire        clock,
  // Write word from the bench and the device's drive state.
  input  wire        drive,
  input  wire [35:0] wordIn,
  input  wire        dataOe,
  // Lanes as the device sees them.
  output wire [31:0] dataIn,
  output wire [3:0]  parityLanesIn
);
  reg  [35:0] lastWord_r = 36'h0_0000_0000;
  // Drive only once the device has let go, so the two never fight.
  wire        put = drive && !dataOe;
  // Released lanes show a moving pattern, never a stale word a device could rely on.
  wire [35:0] lanes = put ? wordIn : ~lastWord_r;
  assign dataIn        = lanes[31:0];
  assign parityLanesIn = lanes[35:32];
  // Keep the last word and walk it while idle.
  always @(posedge clock)
  begin
    if (put)
      lastWord_r <= wordIn;
    else
      lastWord_r <= {lastWord_r[34:0], ~lastWord_r[35]};
  end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the burst SRAM port.
`timescale 1ns/1ps
`include "burst_sram_defs.vh"

module testbench;
  reg         clock = 1'b0;
  reg         rst = 1'b0;
  reg         qualN = 1'b0, cs1N = 1'b1, cs2 = 1'b0, cs3N = 1'b1;
  reg         adv = 1'b0, wrN = 1'b1, oeN = 1'b0, order = 1'b0, sleepReq = 1'b0, drv = 1'b0;
  reg  [3:0]  bwN = 4'hF;
  reg  [18:0] addr = 19'h0_0000;
  reg  [35:0] wd = 36'h0_0000_0000;
  wire [31:0] dIn, dOut;
  wire [3:0]  pIn, pOut;
  wire        oe, asleep;
  integer     err_total = 0;
  integer     compares = 0;

  // 50 MHz clock.
  always #10 clock = ~clock;

  burst_sram_port dut_u
  (
    .clock(clock), .rst(rst), .clockQualifierN(qualN), .chipSelectFirstN(cs1N),
    .chipSelectSecond(cs2), .chipSelectThirdN(cs3N), .advanceLoad(adv), .writeEnableN(wrN),
    .byteLaneWriteSelectN(bwN), .address(addr), .outputDriveEnableN(oeN), .burstOrder(order),
    .sleepRequest(sleepReq), .dataIn(dIn), .parityLanesIn(pIn), .dataOut(dOut),
    .parityLanesOut(pOut), .dataOe(oe), .asleep(asleep)
  );
  lane_driver ctl_u
  (
    .clock(clock), .drive(drv), .wordIn(wd), .dataOe(oe), .dataIn(dIn), .parityLanesIn(pIn)
  );

  task check(input [47:0] name, input [35:0] seen, input [35:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("Error %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask

  // Per-address word, so any burst order can be checked.
  function [35:0] word(input [18:0] a);
    word = {a[3:0], 13'h1A5A, a};
  endfunction

  function [18:0] off(input [18:0] a, input integer s);
    off = {a[18:2], order ? a[1:0] ^ s[1:0] : a[1:0] + s[1:0]};
  endfunction

  // One cycle of controls; returns 1 ns after the edge that took them.
  task step(input q, s, a, w, input [3:0] b, input [18:0] ad, input d, input [35:0] x);
  begin
    qualN = q;
    cs1N = !s;
    cs2 = s;
    cs3N = !s;
    adv = a;
    wrN = w;
    bwN = b;
    addr = ad;
    drv = d;
    wd = x;
    @(posedge clock);
    #1;
  end
  endtask

  task idle(input integer n);
    integer i;
  begin
    for (i = 0; i < n; i = i + 1)
      step(1'b0, 1'b0, 1'b0, 1'b1, 4'hF, 19'h0_0000, 1'b0, 36'h0_0000_0000);
  end
  endtask

  // Burst of len from a; continues carry junk selects, strobe and address.
  task run(input w, input [18:0] a, input integer len, input [3:0] b, input [35:0] x, input hold);
    integer k;
  begin
    for (k = 0; k < len + 2; k = k + 1)
    begin
      if (hold && k == 2)
      begin
        step(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, ~a, 1'b0, 36'h0_0000_0000);
        check("stall", {pOut, dOut}, word(off(a, 0)) ^ x);
      end
      step(1'b0, k == 0, k > 0 && k < len, k == 0 ? w : !w, b, k == 0 ? a : ~a,
           !w && k >= 2, word(off(a, k - 2)) ^ x);
      if (w && k >= 1 && k <= len)
      begin
        check("rdata", {pOut, dOut}, word(off(a, k - 1)) ^ x);
        check("rdrive", oe, !oeN);
      end
      if (!w && k >= 1)
        check("wfloat", oe, 1'b0);
    end
    check("float", oe, 1'b0);
  end
  endtask

  task t_rw;
  begin
    run(1'b0, 19'h0_0100, 1, 4'h0, 36'h0_0000_0000, 1'b0);
    run(1'b1, 19'h0_0100, 1, 4'hF, 36'h0_0000_0000, 1'b0);
    run(1'b0, 19'h0_0100, 1, 4'hA, 36'hF_FFFF_FFFF, 1'b0);
    run(1'b1, 19'h0_0100, 1, 4'hF, 36'h5_00FF_00FF, 1'b0);
    $display("test read write done");
  end
  endtask

  task t_burst;
  begin
    run(1'b0, 19'h0_0201, 4, 4'h0, 36'h0_0000_0000, 1'b0);
    order = 1'b1;
    idle(3);
    run(1'b1, 19'h0_0202, 4, 4'hF, 36'h0_0000_0000, 1'b1);
    order = 1'b0;
    idle(3);
    run(1'b1, 19'h0_0203, 4, 4'hF, 36'h0_0000_0000, 1'b0);
    oeN = 1'b1;
    run(1'b1, 19'h0_0200, 2, 4'hF, 36'h0_0000_0000, 1'b0);
    oeN = 1'b0;
    $display("test burst done");
  end
  endtask

  task t_sleep;
  begin
    sleepReq = 1'b1;
    idle(1);
    check("asleep", asleep, 1'b0);
    idle(1);
    check("asleep", asleep, 1'b1);
    idle(4);
    sleepReq = 1'b0;
    idle(1);
    check("asleep", asleep, 1'b1);
    idle(3);
    check("asleep", asleep, 1'b0);
    run(1'b1, 19'h0_0202, 1, 4'hF, 36'h0_0000_0000, 1'b0);
    $display("test sleep done");
  end
  endtask

  task tally_and_finish;
  begin
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // Reset for ten cycles, then the scenarios in turn.
  initial
  begin
    #1;
    rst = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    check("pwrup", {asleep, oe}, 2'b00);
    rst = 1'b0;
    t_rw;
    t_burst;
    t_sleep;
    tally_and_finish;
  end
endmodule
